/* logic/pspar_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts for the panel settings bank
// Assumes: 40 MHz clock
// Notes: addresses are word indices on the plain register port
`ifndef PSPAR_CFG_SVH
`define PSPAR_CFG_SVH

`define PSPAR_ADDR_W 4
`define PSPAR_OFF_DIR 4'h0
`define PSPAR_OFF_LANG 4'h1
`define PSPAR_OFF_DIAL_LOCK 4'h2
`define PSPAR_OFF_STEP 4'h3
`define PSPAR_OFF_BEEP 4'h4
`define PSPAR_OFF_CONTRAST 4'h5
`define PSPAR_OFF_CTRL 4'h6
`define PSPAR_OFF_STATUS 4'h7
`define PSPAR_OFF_FREQ 4'h8

`define PSPAR_RST_DIR 1'h0
`define PSPAR_RST_LANG 3'h1
`define PSPAR_RST_DIAL_LOCK 4'h0
`define PSPAR_RST_STEP 10'h000
`define PSPAR_RST_BEEP 1'h1
`define PSPAR_RST_CONTRAST 6'h3A
`define PSPAR_RST_GROUP 1'h0
`define PSPAR_RST_SPEED_SEL 1'h0

// dial step values in hundredths
`define PSPAR_STEP_0 10'h000
`define PSPAR_STEP_001 10'h001
`define PSPAR_STEP_010 10'h00A
`define PSPAR_STEP_100 10'h064
`define PSPAR_STEP_1000 10'h3E8

// dial/lock codes
`define PSPAR_DL_FREQ 4'h0
`define PSPAR_DL_POT 4'h1
`define PSPAR_DL_FREQ_LOCK 4'hA
`define PSPAR_DL_POT_LOCK 4'hB
`define PSPAR_DL_LOCK_BIT 3
`define PSPAR_DL_POT_BIT 0

// display thresholds in hundredths
`define PSPAR_FREQ_TH_100 20'h02710
`define PSPAR_FREQ_TH_1000 20'h186A0
`define PSPAR_FREQ_MAX 20'hFFFFF

// mode key hold time
`define PSPAR_HOLD_MS 2000
`define PSPAR_CLK_KHZ 40000
`define PSPAR_HOLD_CYC (`PSPAR_HOLD_MS * `PSPAR_CLK_KHZ)

`endif

/* logic/pspar_pkg.sv */
// Purpose: types for the panel settings bank
// Assumes: nothing
// Notes: constants live in pspar_cfg.svh
`default_nettype none
package pspar_pkg;
    typedef enum logic [1:0] {
        PSPAR_EDIT_SETFREQ = 2'h0,
        PSPAR_EDIT_OTHER = 2'h1
    } pspar_edit_t;

    typedef struct packed {
        logic run;
        logic stop;
        logic mode;
        logic write;
        logic dial_up;
        logic dial_dn;
        logic other_key;
    } pspar_keys_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pspar_bus_t;
endpackage
`default_nettype wire

/* logic/pspar_bank.sv */
// Purpose: settings bank behind the operation panel and handheld parameter unit
// Assumes: keys are asynchronous pins; dial up/down are one event per click after sync
// Notes: frequency held in hundredths of a unit; speed display uses the same value
`include "pspar_cfg.svh"
`default_nettype none
module pspar_bank (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire pspar_pkg::pspar_bus_t bus_in,
    output logic [31:0] rdata_out,
    // panel pins
    input wire pspar_pkg::pspar_keys_t keys_in,
    input wire logic unit_present_in,
    input wire pspar_pkg::pspar_edit_t edit_mode_in,
    // drive and panel outputs
    output logic run_fwd_out,
    output logic run_rev_out,
    output logic stop_out,
    output logic lock_ind_out,
    output logic beep_out,
    output logic [5:0] contrast_out,
    output logic contrast_visible_out,
    output logic [19:0] freq_out,
    output logic pot_mode_out
);
    localparam int NK = 7;
    localparam logic [26:0] HOLD_CYC = 27'(`PSPAR_HOLD_CYC);

    // -------------------------------------------------
    // registers
    // -------------------------------------------------
    logic dir;
    logic [2:0] lang;
    logic [3:0] dial_lock;
    logic [3:0] dial_lock_act;
    logic [9:0] step;
    logic beep_en;
    logic [5:0] contrast_pend;
    logic [5:0] contrast;
    logic group_sel;
    logic speed_sel;
    logic [26:0] hold_cnt;
    logic [19:0] freq;

    // -------------------------------------------------
    // pin synchronisers: change counts when stages 2 and 3 agree
    // -------------------------------------------------
    logic [NK-1:0] key_raw;
    logic [NK-1:0] key_s1;
    logic [NK-1:0] key_s2;
    logic [NK-1:0] key_s3;
    logic [NK-1:0] key_lvl;
    logic [NK-1:0] key_prev;
    logic [NK-1:0] key_rise;
    assign key_raw = keys_in;

    genvar g;
    generate
        for (g = 0; g < NK; g++)
        begin : g_sync
            always_ff @(posedge clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    key_s1[g] <= 1'b0;
                    key_s2[g] <= 1'b0;
                    key_s3[g] <= 1'b0;
                    key_lvl[g] <= 1'b0;
                    key_prev[g] <= 1'b0;
                end
                else
                begin
                    key_s1[g] <= key_raw[g];
                    key_s2[g] <= key_s1[g];
                    key_s3[g] <= key_s2[g];
                    if (key_s2[g] == key_s3[g])
                    begin
                        key_lvl[g] <= key_s3[g];
                    end
                    key_prev[g] <= key_lvl[g];
                end
            end
            assign key_rise[g] = key_lvl[g] & ~key_prev[g];
        end
    endgenerate

    // bit order follows the struct: run stop mode write up dn other
    wire k_run = key_rise[6];
    wire k_stop = key_rise[5];
    wire k_mode_lvl = key_lvl[4];
    wire k_write = key_rise[3];
    wire k_up = key_rise[2];
    wire k_dn = key_rise[1];
    wire any_press = |key_rise;

    // -------------------------------------------------
    // register decode and range checks
    // -------------------------------------------------
    wire [31:0] wd = bus_in.wdata;
    wire wr = bus_in.wr;
    wire [3:0] a = bus_in.addr;
    wire grp_ok = (group_sel == 1'b0);
    wire dir_ok = (wd[31:1] == 31'h0);
    wire lang_ok = (wd[31:3] == 29'h0);
    wire dl_ok = (wd[3:0] == `PSPAR_DL_FREQ) || (wd[3:0] == `PSPAR_DL_POT) ||
                 (wd[3:0] == `PSPAR_DL_FREQ_LOCK) || (wd[3:0] == `PSPAR_DL_POT_LOCK);
    wire dl_ok_w = dl_ok && (wd[31:4] == 28'h0);
    wire step_ok = (wd[31:10] == 22'h0) &&
                   ((wd[9:0] == `PSPAR_STEP_0) || (wd[9:0] == `PSPAR_STEP_001) ||
                    (wd[9:0] == `PSPAR_STEP_010) || (wd[9:0] == `PSPAR_STEP_100) ||
                    (wd[9:0] == `PSPAR_STEP_1000));
    wire beep_ok = (wd[31:1] == 31'h0);
    wire con_ok = (wd[31:6] == 26'h0);

    wire wr_dir = wr && (a == `PSPAR_OFF_DIR) && grp_ok && dir_ok;
    wire wr_lang = wr && (a == `PSPAR_OFF_LANG) && grp_ok && lang_ok;
    wire wr_dl = wr && (a == `PSPAR_OFF_DIAL_LOCK) && grp_ok && dl_ok_w;
    wire wr_step = wr && (a == `PSPAR_OFF_STEP) && grp_ok && step_ok;
    // beep and contrast bypass the write-protect gate
    wire wr_beep = wr && (a == `PSPAR_OFF_BEEP) && beep_ok;
    wire wr_con = wr && (a == `PSPAR_OFF_CONTRAST) && con_ok;
    wire wr_ctrl = wr && (a == `PSPAR_OFF_CTRL);

    // -------------------------------------------------
    // key lock and dial step
    // -------------------------------------------------
    // mode key hold detection
    wire lock_change = (dial_lock[`PSPAR_DL_LOCK_BIT] != dial_lock_act[`PSPAR_DL_LOCK_BIT]);
    wire hold_done = (hold_cnt == HOLD_CYC);
    // pot bit applies at once; lock bit waits for the hold
    wire next_lock_bit = (lock_change && !hold_done) ? dial_lock_act[`PSPAR_DL_LOCK_BIT] :
                         dial_lock[`PSPAR_DL_LOCK_BIT];
    wire [3:0] next_dial_lock_act = {next_lock_bit, dial_lock[2:0]};
    wire locked = dial_lock_act[`PSPAR_DL_LOCK_BIT];
    wire dial_ok = !locked;

    // base step, 0 means one hundredth
    wire [9:0] base_step = (step == `PSPAR_STEP_0) ? `PSPAR_STEP_001 : step;
    wire ge_1000 = speed_sel && (freq >= `PSPAR_FREQ_TH_1000);
    wire ge_100 = freq >= `PSPAR_FREQ_TH_100;
    wire [9:0] floor_step = ge_1000 ? `PSPAR_STEP_100 : (ge_100 ? `PSPAR_STEP_010 : `PSPAR_STEP_001);
    wire [9:0] cfg_step = (base_step > floor_step) ? base_step : floor_step;
    // configured step only in set-frequency editing
    wire [9:0] eff_step = (edit_mode_in == pspar_pkg::PSPAR_EDIT_SETFREQ) ? cfg_step : floor_step;
    wire [20:0] sum_up = {1'b0, freq} + {11'h000, eff_step};
    wire [19:0] next_up = sum_up[20] ? `PSPAR_FREQ_MAX : sum_up[19:0];
    wire [19:0] next_dn = (freq > {10'h000, eff_step}) ? (freq - {10'h000, eff_step}) : 20'h00000;
    wire [19:0] next_freq = (dial_ok && k_up) ? next_up : ((dial_ok && k_dn) ? next_dn : freq);

    // -------------------------------------------------
    // register storage
    // -------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dir <= `PSPAR_RST_DIR;
            lang <= `PSPAR_RST_LANG;
            dial_lock <= `PSPAR_RST_DIAL_LOCK;
            step <= `PSPAR_RST_STEP;
            beep_en <= `PSPAR_RST_BEEP;
            contrast_pend <= `PSPAR_RST_CONTRAST;
            group_sel <= `PSPAR_RST_GROUP;
            speed_sel <= `PSPAR_RST_SPEED_SEL;
        end
        else
        begin
            if (wr_dir)
            begin
                dir <= wd[0];
            end
            if (wr_lang)
            begin
                lang <= wd[2:0];
            end
            if (wr_dl)
            begin
                dial_lock <= wd[3:0];
            end
            if (wr_step)
            begin
                step <= wd[9:0];
            end
            // a refused write gives no error flag, so software must read back to confirm
            if (wr_beep)
            begin
                beep_en <= wd[0];
            end
            if (wr_con)
            begin
                contrast_pend <= wd[5:0];
            end
            if (wr_ctrl)
            begin
                group_sel <= wd[0];
                speed_sel <= wd[1];
            end
        end
    end

    // hold counter stops at its target so a very long press cannot wrap back to zero
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dial_lock_act <= `PSPAR_RST_DIAL_LOCK;
            hold_cnt <= 27'h0000000;
        end
        else
        begin
            dial_lock_act <= next_dial_lock_act;
            if (k_mode_lvl && lock_change && !hold_done)
            begin
                hold_cnt <= hold_cnt + 27'h0000001;
            end
            else if (!k_mode_lvl || !lock_change)
            begin
                hold_cnt <= 27'h0000000;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            contrast <= `PSPAR_RST_CONTRAST;
            freq <= 20'h00000;
        end
        else
        begin
            if (k_write && !locked)
            begin
                contrast <= contrast_pend;
            end
            freq <= next_freq;
        end
    end

    // -------------------------------------------------
    // handheld unit detect pin synchroniser
    // -------------------------------------------------
    // the unit may be plugged at any time, so its detect pin is filtered like the keys
    logic unit_s1;
    logic unit_s2;
    logic unit_s3;
    logic unit_lvl;
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            unit_s1 <= 1'b0;
            unit_s2 <= 1'b0;
            unit_s3 <= 1'b0;
            unit_lvl <= 1'b0;
        end
        else
        begin
            unit_s1 <= unit_present_in;
            unit_s2 <= unit_s1;
            unit_s3 <= unit_s2;
            if (unit_s2 == unit_s3)
            begin
                unit_lvl <= unit_s3;
            end
        end
    end

    // -------------------------------------------------
    // read mux
    // -------------------------------------------------
    logic [31:0] rmux;
    assign rmux = (a == `PSPAR_OFF_DIR) ? {31'h0, dir} :
                  (a == `PSPAR_OFF_LANG) ? {29'h0, lang} :
                  (a == `PSPAR_OFF_DIAL_LOCK) ? {28'h0, dial_lock} :
                  (a == `PSPAR_OFF_STEP) ? {22'h0, step} :
                  (a == `PSPAR_OFF_BEEP) ? {31'h0, beep_en} :
                  (a == `PSPAR_OFF_CONTRAST) ? {26'h0, contrast} :
                  (a == `PSPAR_OFF_CTRL) ? {30'h0, speed_sel, group_sel} :
                  (a == `PSPAR_OFF_STATUS) ? {26'h0, unit_lvl, locked, dial_lock_act} :
                  (a == `PSPAR_OFF_FREQ) ? {12'h0, freq} : 32'h0;

    // -------------------------------------------------
    // outputs, all registered
    // -------------------------------------------------
    // read data is zero outside its slot so a stray sample never looks valid
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_out <= 32'h0;
        end
        else
        begin
            rdata_out <= bus_in.rd ? rmux : 32'h0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            run_fwd_out <= 1'b0;
            run_rev_out <= 1'b0;
            stop_out <= 1'b0;
        end
        else
        begin
            run_fwd_out <= k_run && dial_ok && !dir;
            run_rev_out <= k_run && dial_ok && dir;
            // stop works under lock
            // stop skips the lock gate on purpose: a locked panel must still halt the motor
            stop_out <= k_stop;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lock_ind_out <= 1'b0;
            beep_out <= 1'b0;
            contrast_out <= `PSPAR_RST_CONTRAST;
            contrast_visible_out <= 1'b0;
            freq_out <= 20'h00000;
            pot_mode_out <= 1'b0;
        end
        else
        begin
            lock_ind_out <= locked && (key_lvl[6] | key_lvl[4] | key_lvl[3] |
                                       key_lvl[2] | key_lvl[1] | key_lvl[0]);
            beep_out <= beep_en && any_press;
            contrast_out <= contrast;
            // contrast shown only with unit connected
            contrast_visible_out <= unit_lvl;
            freq_out <= freq;
            pot_mode_out <= dial_lock_act[`PSPAR_DL_POT_BIT];
        end
    end
endmodule
`default_nettype wire

/* dv/pspar_bank_chk.sv */
// Purpose: port assertions for the panel settings bank
// Assumes: one 40 MHz domain, keys held several cycles
// Notes: the two-second lock hold is out of reach, lock checks stay idle
`default_nettype none
module pspar_bank_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // watched inputs
    input wire pspar_pkg::pspar_bus_t bus_in,
    input wire pspar_pkg::pspar_keys_t keys_in,
    input wire logic unit_present_in,
    // watched outputs
    input wire logic [31:0] rdata_out,
    input wire logic run_fwd_out,
    input wire logic run_rev_out,
    input wire logic stop_out,
    input wire logic lock_ind_out,
    input wire logic beep_out,
    input wire logic [5:0] contrast_out,
    input wire logic contrast_visible_out,
    input wire logic [19:0] freq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since reset release, saturating; the unit pin needs five of them to reach the output
    logic [2:0] rst_age;
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_age <= 3'h0;
        end
        else if (rst_age != 3'h7)
        begin
            rst_age <= rst_age + 3'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // write key seen through the synchroniser
    sequence s_write_seen;
        $past(keys_in.write, 3) || $past(keys_in.write, 5) || $past(keys_in.write, 7);
    endsequence
    a_run_single_dir: assert property ((run_fwd_out || run_rev_out) |->
        !(run_fwd_out && run_rev_out) ##1 !(run_fwd_out || run_rev_out)) else $error("run pulse bad");
    a_lock_blocks_run: assert property (lock_ind_out |-> !(run_fwd_out || run_rev_out))
        else $error("run while locked");
    a_lock_freq_hold: assert property (lock_ind_out |=> $stable(freq_out)) else $error("dial while locked");
    a_stop_pulse_once: assert property (stop_out |=> !stop_out) else $error("stop pulse long");
    a_beep_pulse_once: assert property (beep_out |=> !beep_out) else $error("beep pulse long");
    a_contrast_on_key: assert property ($changed(contrast_out) |-> s_write_seen)
        else $error("contrast moved without write key");
    a_visible_follows: assert property ((rst_age > 3'h4) |->
        contrast_visible_out == $past(unit_present_in, 5)) else $error("visibility wrong");
    a_rdata_idle_zero: assert property ($past(resetn_in) && !$past(bus_in.rd) |-> rdata_out == 32'h0)
        else $error("read data outside slot");
endmodule
bind pspar_bank pspar_bank_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in),
    .keys_in(keys_in), .unit_present_in(unit_present_in), .rdata_out(rdata_out),
    .run_fwd_out(run_fwd_out), .run_rev_out(run_rev_out), .stop_out(stop_out),
    .lock_ind_out(lock_ind_out), .beep_out(beep_out), .contrast_out(contrast_out),
    .contrast_visible_out(contrast_visible_out), .freq_out(freq_out));
`default_nettype wire

/* dv/pspar_panel.sv */
// Purpose: behavioural operation panel and handheld unit
// Assumes: keys are plain levels, high while pressed
// Notes: a short hold still passes the design's key synchroniser
`default_nettype none
module pspar_panel (
    // clock
    input wire logic clk_in,
    // panel pins
    output var pspar_pkg::pspar_keys_t keys_out,
    output var logic unit_present_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        keys_out = '0;
        unit_present_out = 1'b1;
    end
    task automatic press(input logic [6:0] mask, input int hold);
        @(posedge clk_in);
        keys_out <= pspar_pkg::pspar_keys_t'(mask);
        repeat (hold) @(posedge clk_in);
        keys_out <= '0;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic plug(input logic on);
        @(posedge clk_in);
        unit_present_out <= on;
        repeat (8) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

/* dv/panel_setting_parameters_bench.sv */
// Purpose: self-checking bench for the panel settings bank
// Assumes: 40 MHz clock, lock hold count left at full length
// Notes: lock entry needs two seconds, so only its delay is seen
`include "pspar_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module panel_setting_parameters_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    pspar_pkg::pspar_bus_t bus_in = '0;
    pspar_pkg::pspar_edit_t edit_mode_in = pspar_pkg::PSPAR_EDIT_SETFREQ;
    pspar_pkg::pspar_keys_t keys;
    logic unit_present;
    logic [31:0] rdata_out;
    logic run_fwd_out, run_rev_out, stop_out, lock_ind_out, beep_out, contrast_visible_out, pot_mode_out;
    logic [5:0] contrast_out;
    logic [19:0] freq_out;
    logic [31:0] rd_v;
    int error_cnt = 0;
    int n_checks = 0;
    int n_fwd = 0, n_rev = 0, n_beep = 0, n_stop = 0;
    always #12.5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        n_fwd <= n_fwd + int'(run_fwd_out);
        n_rev <= n_rev + int'(run_rev_out);
        n_beep <= n_beep + int'(beep_out);
        n_stop <= n_stop + int'(stop_out);
    end
    pspar_panel panel (.clk_in(clk_in), .keys_out(keys), .unit_present_out(unit_present));
    pspar_bank dut (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in), .rdata_out(rdata_out),
        .keys_in(keys), .unit_present_in(unit_present), .edit_mode_in(edit_mode_in),
        .run_fwd_out(run_fwd_out), .run_rev_out(run_rev_out), .stop_out(stop_out),
        .lock_ind_out(lock_ind_out), .beep_out(beep_out), .contrast_out(contrast_out),
        .contrast_visible_out(contrast_visible_out), .freq_out(freq_out), .pot_mode_out(pot_mode_out));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_in.wr <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        bus_in <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_in.rd <= 1'b0;
        #1 rd_v = rdata_out;
        chk(nm, e, rd_v);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rchk("dir", `PSPAR_OFF_DIR, 32'h0);
        rchk("lang", `PSPAR_OFF_LANG, 32'h1);
        rchk("dial_lock", `PSPAR_OFF_DIAL_LOCK, 32'h0);
        rchk("step", `PSPAR_OFF_STEP, 32'h0);
        rchk("beep", `PSPAR_OFF_BEEP, 32'h1);
        rchk("contrast", `PSPAR_OFF_CONTRAST, 32'h3A);
        `CHK("contrast_out", 6'h3A, contrast_out);
        rchk("unmapped", 4'hF, 32'h0);
    endtask
    task automatic t_ranges;
        for (int i = 0; i < 8; i++)
        begin
            wr(`PSPAR_OFF_LANG, 32'(i));
            rchk("lang", `PSPAR_OFF_LANG, 32'(i));
        end
        wr(`PSPAR_OFF_LANG, 32'h8);
        rchk("lang_bad", `PSPAR_OFF_LANG, 32'h7);
        wr(`PSPAR_OFF_DIR, 32'h2);
        rchk("dir_bad", `PSPAR_OFF_DIR, 32'h0);
        wr(`PSPAR_OFF_DIAL_LOCK, 32'h2);
        rchk("dl_bad", `PSPAR_OFF_DIAL_LOCK, 32'h0);
        wr(`PSPAR_OFF_STEP, 32'h5);
        rchk("step_bad", `PSPAR_OFF_STEP, 32'h0);
        wr(`PSPAR_OFF_BEEP, 32'h2);
        rchk("beep_bad", `PSPAR_OFF_BEEP, 32'h1);
    endtask
    task automatic t_group;
        wr(`PSPAR_OFF_CTRL, 32'h1);
        wr(`PSPAR_OFF_DIR, 32'h1);
        rchk("dir_grp", `PSPAR_OFF_DIR, 32'h0);
        wr(`PSPAR_OFF_BEEP, 32'h0);
        rchk("beep_grp", `PSPAR_OFF_BEEP, 32'h0);
        wr(`PSPAR_OFF_CONTRAST, 32'h14);
        wr(`PSPAR_OFF_CONTRAST, 32'h40);
        rchk("held", `PSPAR_OFF_CONTRAST, 32'h3A);
        panel.press(7'h08, 8);
        `CHK("contrast_out", 6'h14, contrast_out);
        wr(`PSPAR_OFF_CTRL, 32'h0);
        panel.plug(1'b0);
        `CHK("visible", 1'b0, contrast_visible_out);
        panel.plug(1'b1);
        `CHK("visible", 1'b1, contrast_visible_out);
    endtask
    task automatic t_run;
        panel.press(7'h40, 8);
        `CHK("fwd", 1, n_fwd);
        `CHK("silent", 0, n_beep);
        wr(`PSPAR_OFF_BEEP, 32'h1);
        wr(`PSPAR_OFF_DIR, 32'h1);
        panel.press(7'h40, 8);
        `CHK("rev", 1, n_rev);
        `CHK("beep", 1, n_beep);
        panel.press(7'h20, 8);
        `CHK("stop", 1, n_stop);
    endtask
    task automatic t_dial;
        logic [31:0] st [5] = '{32'h0, 32'h1, 32'hA, 32'h64, 32'h3E8};
        logic [31:0] f = 32'h0;
        for (int i = 0; i < 5; i++)
        begin
            wr(`PSPAR_OFF_STEP, st[i]);
            panel.press(7'h04, 8);
            f = f + ((i == 0) ? 32'h1 : st[i]);
            `CHK("dial_step", f, freq_out);
        end
        repeat (9) panel.press(7'h04, 8);
        wr(`PSPAR_OFF_STEP, 32'h1);
        panel.press(7'h04, 8);
        `CHK("floor_10", f + 32'h2332, freq_out);
        wr(`PSPAR_OFF_STEP, 32'h3E8);
        @(posedge clk_in) edit_mode_in <= pspar_pkg::PSPAR_EDIT_OTHER;
        panel.press(7'h04, 8);
        @(posedge clk_in) edit_mode_in <= pspar_pkg::PSPAR_EDIT_SETFREQ;
        panel.press(7'h02, 8);
        rchk("other_mode", `PSPAR_OFF_FREQ, f + 32'h1F54);
        f = f + 32'h1F54;
        wr(`PSPAR_OFF_CTRL, 32'h2);
        repeat (91) panel.press(7'h04, 8);
        `CHK("speed_step", f + 32'h16378, freq_out);
        wr(`PSPAR_OFF_STEP, 32'hA);
        panel.press(7'h04, 8);
        `CHK("floor_100", f + 32'h163DC, freq_out);
    endtask
    task automatic t_lock;
        logic [31:0] cd [4] = '{32'h0, 32'h1, 32'hA, 32'hB};
        for (int i = 0; i < 4; i++)
        begin
            wr(`PSPAR_OFF_DIAL_LOCK, cd[i]);
            rchk("dl", `PSPAR_OFF_DIAL_LOCK, cd[i]);
            `CHK("pot", cd[i][0], pot_mode_out);
        end
        panel.press(7'h10, 100);
        panel.press(7'h40, 8);
        `CHK("no_lock_yet", 2, n_rev);
        `CHK("no_ind", 1'b0, lock_ind_out);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset;
        t_ranges;
        t_group;
        t_run;
        t_dial;
        t_lock;
        stop_test;
    end
    // a hang counts as a mismatch
    initial
    begin
        repeat (50000) @(posedge clk_in);
        error_cnt++;
        stop_test;
    end
endmodule
`default_nettype wire
